/* ram_pkg.sv */
// shared constants and carriers for the small ram block
package ram_pkg;
  localparam int unsigned TOTAL_BITS  = 576;
  localparam int unsigned MAX_WIDTH   = 18;
  localparam int unsigned ADDR_W      = 9;
  localparam int unsigned DEPTH_WORDS = TOTAL_BITS / MAX_WIDTH;

  typedef enum logic [2:0] {
    MODE_SDP   = 3'h0,
    MODE_SP    = 3'h1,
    MODE_FIFO  = 3'h2,
    MODE_ROM   = 3'h3,
    MODE_SHIFT = 3'h4
  } ram_mode_t;

  typedef enum logic [2:0] {
    CFG_512X1 = 3'h0,
    CFG_256X2 = 3'h1,
    CFG_128X4 = 3'h2,
    CFG_64X8  = 3'h3,
    CFG_64X9  = 3'h4,
    CFG_32X16 = 3'h5,
    CFG_32X18 = 3'h6
  } ram_shape_t;

  typedef struct packed {
    logic                 en;
    logic [ADDR_W-1:0]    addr;
    logic [MAX_WIDTH-1:0] data;
  } wr_req_t;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
  } rd_req_t;

  localparam logic [ADDR_W-1:0]    ADDR_ZERO = 9'h000;
  localparam logic [MAX_WIDTH-1:0] DATA_ZERO = 18'h00000;
endpackage : ram_pkg

/* ram_array.sv */
// bit-addressed 576-bit storage array with shape-aware access
`timescale 1ns/1ps
module ram_array
  import ram_pkg::*;
#(
  parameter string INIT_FILE_UNUSED = ""
) (
  input  wire logic                    i_core_clk,
  input  wire ram_pkg::ram_shape_t     i_shape,
  input  wire logic                    i_load_en,
  input  wire logic [ADDR_W-1:0]       i_load_addr,
  input  wire logic                    i_load_bit,
  input  wire logic                    i_we,
  input  wire logic [ADDR_W-1:0]       i_waddr,
  input  wire logic [MAX_WIDTH-1:0]    i_wdata,
  input  wire logic [ADDR_W-1:0]       i_raddr,
  output logic      [MAX_WIDTH-1:0]    o_rdata
);
  import ram_pkg::*;

  logic [TOTAL_BITS-1:0] mem_q;

  function automatic int unsigned shape_width(input ram_shape_t s);
    unique case (s)
      CFG_512X1: shape_width = 1;
      CFG_256X2: shape_width = 2;
      CFG_128X4: shape_width = 4;
      CFG_64X8:  shape_width = 8;
      CFG_64X9:  shape_width = 9;
      CFG_32X16: shape_width = 16;
      CFG_32X18: shape_width = 18;
      default:   shape_width = 1;
    endcase
  endfunction : shape_width

  // all shapes pack words at addr*width mod 576; plain shapes reach the top 64 bits only at addresses past their depth, and 512x1 never does
  function automatic int unsigned base_of(input ram_shape_t s, input logic [ADDR_W-1:0] a);
    int unsigned w;
    w = shape_width(s);
    base_of = (int'(a) * w) % TOTAL_BITS;
  endfunction : base_of

  int unsigned wbase;
  int unsigned rbase;
  int unsigned wid;
  always_comb begin
    wid   = shape_width(i_shape);
    wbase = base_of(i_shape, i_waddr);
    rbase = base_of(i_shape, i_raddr);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_load_en) begin
      mem_q[i_load_addr] <= i_load_bit;
    end else if (i_we) begin
      for (int b = 0; b < MAX_WIDTH; b++) begin
        if (b < wid && (wbase + b) < TOTAL_BITS) begin
          mem_q[wbase + b] <= i_wdata[b];
        end
      end
    end
  end

  always_comb begin
    o_rdata = DATA_ZERO;
    for (int b = 0; b < MAX_WIDTH; b++) begin
      if (b < wid && (rbase + b) < TOTAL_BITS) begin
        o_rdata[b] = mem_q[rbase + b];
      end
    end
  end
endmodule : ram_array

/* small_ram_block.sv */
// small dual-port ram block top: port registers, clocking choice, clears
`timescale 1ns/1ps
module small_ram_block (
  input  wire logic                          i_core_clk,
  input  wire logic                          i_rst_n,
  input  wire ram_pkg::ram_mode_t            i_mode,
  input  wire ram_pkg::ram_shape_t           i_shape,
  input  wire logic                          i_wr_clk_sel,
  input  wire logic                          i_rd_clk_sel,
  input  wire logic                          i_out_clk_sel,
  input  wire logic                          i_out_bypass,
  input  wire logic                          i_in_clr,
  input  wire logic                          i_out_clr,
  input  wire logic                          i_clk_b_tick,
  input  wire logic                          i_load_en,
  input  wire logic [ram_pkg::ADDR_W-1:0]    i_load_addr,
  input  wire logic                          i_load_bit,
  input  wire ram_pkg::wr_req_t              i_wr,
  input  wire ram_pkg::rd_req_t              i_rd,
  output logic      [ram_pkg::MAX_WIDTH-1:0] o_rdata,
  output logic                               o_rd_valid
);
  import ram_pkg::*;

  // both block clocks share i_core_clk; clock b is qualified by a same-domain tick
  logic wr_tick;
  logic rd_tick;
  logic out_tick;
  always_comb begin
    wr_tick  = i_wr_clk_sel  ? i_clk_b_tick : 1'b1;
    rd_tick  = i_rd_clk_sel  ? i_clk_b_tick : 1'b1;
    out_tick = i_out_clk_sel ? i_clk_b_tick : 1'b1;
  end

  logic in_clr_n;
  logic out_clr_n;
  assign in_clr_n  = i_rst_n & ~i_in_clr;
  assign out_clr_n = i_rst_n & ~i_out_clr;

  wr_req_t wr_q;
  rd_req_t rd_q;
  logic    writable;
  assign writable = (i_mode != MODE_ROM);

  // write registers always in path
  always_ff @(posedge i_core_clk or negedge in_clr_n) begin
    if (!in_clr_n) begin
      wr_q <= '0;
    end else if (wr_tick) begin
      wr_q.en   <= i_wr.en & writable;
      wr_q.data <= i_wr.data;
      wr_q.addr <= (i_mode == MODE_SHIFT) ? i_rd.addr : i_wr.addr;
    end
  end

  // single-port shares one address for both directions
  always_ff @(posedge i_core_clk or negedge in_clr_n) begin
    if (!in_clr_n) begin
      rd_q <= '0;
    end else if (rd_tick) begin
      rd_q.en   <= i_rd.en;
      rd_q.addr <= (i_mode == MODE_SP) ? i_wr.addr : i_rd.addr;
    end
  end

  logic [MAX_WIDTH-1:0] arr_rdata;
  ram_array u_array (
    .i_core_clk  (i_core_clk),
    .i_shape     (i_shape),
    .i_load_en   (i_load_en),
    .i_load_addr (i_load_addr),
    .i_load_bit  (i_load_bit),
    .i_we        (wr_q.en & wr_tick),
    .i_waddr     (wr_q.addr),
    .i_wdata     (wr_q.data),
    .i_raddr     (rd_q.addr),
    .o_rdata     (arr_rdata)
  );

  // read latch: cleared input regs reach memory output only at next edge
  logic [MAX_WIDTH-1:0] mem_out_q;
  logic                 mem_vld_q;
  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_out_q <= DATA_ZERO;
      mem_vld_q <= 1'b0;
    end else if (rd_tick) begin
      mem_vld_q <= rd_q.en;
      if (rd_q.en) begin
        mem_out_q <= arr_rdata;
      end
    end
  end

  logic [MAX_WIDTH-1:0] out_q;
  logic                 out_vld_q;
  always_ff @(posedge i_core_clk or negedge out_clr_n) begin
    if (!out_clr_n) begin
      out_q     <= DATA_ZERO;
      out_vld_q <= 1'b0;
    end else if (out_tick) begin
      out_q     <= mem_out_q;
      out_vld_q <= mem_vld_q;
    end
  end

  // bypass still honours the output clear so it takes effect at once
  always_comb begin
    if (i_out_clr) begin
      o_rdata    = DATA_ZERO;
      o_rd_valid = 1'b0;
    end else if (i_out_bypass) begin
      o_rdata    = mem_out_q;
      o_rd_valid = mem_vld_q;
    end else begin
      o_rdata    = out_q;
      o_rd_valid = out_vld_q;
    end
  end

  out_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_out_clr |-> (o_rdata == DATA_ZERO) && !o_rd_valid)
    else $error("output clear not seen at once");
  in_clear_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_in_clr |-> !wr_q.en && !rd_q.en)
    else $error("input registers not cleared");
  rom_nowrite_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    (i_mode == MODE_ROM) && !$changed(i_mode) |=> !wr_q.en)
    else $error("write reached array in rom mode");
  sequence rd_issue_s;
    !i_in_clr && !i_rd_clk_sel && !i_mode[0] && i_rd.en;
  endsequence
  rd_pipe_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || i_in_clr)
    rd_issue_s |=> ##1 mem_vld_q)
    else $error("read did not reach memory latch");
  wr_hold_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || i_in_clr)
    i_wr_clk_sel && !i_clk_b_tick |=> $stable(wr_q))
    else $error("write registers moved without their clock");
  bypass_path_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    i_out_bypass && !i_out_clr |-> o_rdata == mem_out_q)
    else $error("bypass path wrong");
  out_reg_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n || i_out_clr)
    !i_out_clk_sel |=> out_q == $past(mem_out_q))
    else $error("output register did not follow");
  width_fit_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    DEPTH_WORDS * MAX_WIDTH == TOTAL_BITS)
    else $error("capacity mismatch");

  // full registered path on clock a: request, input reg, latch, output reg
  sequence rd_clock_a_s;
    !i_rd_clk_sel && !i_out_clk_sel && !i_out_bypass;
  endsequence
  rd_latency_a: assert property (@(posedge i_core_clk)
    disable iff (!i_rst_n || i_in_clr || i_out_clr)
    rd_issue_s ##0 rd_clock_a_s |=> ##2 o_rd_valid)
    else $error("read valid late at output");
  latch_follow_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n)
    !i_rd_clk_sel |=> mem_vld_q == $past(rd_q.en))
    else $error("read latch did not follow read register");
endmodule : small_ram_block

/* fabric_user.sv */
// fabric-side user logic model: packs write and read requests
`timescale 1ns/1ps
module fabric_user (
  input  wire logic                          i_we,
  input  wire logic [ram_pkg::ADDR_W-1:0]    i_wa,
  input  wire logic [ram_pkg::MAX_WIDTH-1:0] i_wd,
  input  wire logic                          i_re,
  input  wire logic [ram_pkg::ADDR_W-1:0]    i_ra,
  output ram_pkg::wr_req_t                   o_wr,
  output ram_pkg::rd_req_t                   o_rd
);
  import ram_pkg::*;
  // enables come straight from plain logic cells, no extra stage
  assign o_wr = '{en: i_we, addr: i_wa, data: i_wd};
  assign o_rd = '{en: i_re, addr: i_ra};
endmodule : fabric_user

/* test_small_ram_block.sv */
// self-checking bench for the small ram block
`timescale 1ns/1ps
module test_small_ram_block;
  import ram_pkg::*;
  logic clk = 0, rst_n = 0, byp = 0, iclr = 0, oclr = 0;
  logic le = 0, lb = 0, we = 0, re = 0, vld;
  logic csel = 0, tick = 1;
  logic [8:0] la = 9'h000, wa = 9'h000, ra = 9'h000;
  logic [17:0] wd = 18'h00000, rdata, pat;
  ram_mode_t mode = MODE_SDP;
  wr_req_t wr;
  rd_req_t rd;
  int bad_count = 0, checks_done = 0, cycles = 0;
  localparam logic [26:0] ROWS [4] = '{{9'h000, 18'h3ffff}, {9'h01f, 18'h00001},
                                       {9'h010, 18'h2aaaa}, {9'h001, 18'h15555}};
  always #5 clk = ~clk;
  fabric_user fab (.i_we(we), .i_wa(wa), .i_wd(wd), .i_re(re), .i_ra(ra),
                   .o_wr(wr), .o_rd(rd));
  small_ram_block uut (.i_core_clk(clk), .i_rst_n(rst_n), .i_mode(mode),
    .i_shape(CFG_32X18), .i_wr_clk_sel(csel), .i_rd_clk_sel(csel),
    .i_out_clk_sel(csel), .i_out_bypass(byp), .i_in_clr(iclr), .i_out_clr(oclr),
    .i_clk_b_tick(tick), .i_load_en(le), .i_load_addr(la), .i_load_bit(lb),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_rd_valid(vld));
  task automatic check(input logic [17:0] seen, input logic [17:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic op(input logic w, input logic [8:0] a, input logic [17:0] d,
                    input logic r, input logic [8:0] b);
    @(negedge clk);
    we = w;
    wa = a;
    wd = d;
    re = r;
    ra = b;
    @(negedge clk);
    we = 0;
    re = 0;
  endtask : op
  task automatic rd_chk(input logic [8:0] b, input logic [17:0] exp);
    op(0, 9'h000, 18'h00000, 1, b);
    repeat (4) @(negedge clk);
    check(rdata, exp);
  endtask : rd_chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      report_and_stop();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    check(rdata, 18'h00000);
    check({17'h0, vld}, 18'h00000);
    rst_n = 1;
    $display("reset done");
    // full 32 words of 18 bits: first and last word both reachable
    foreach (ROWS[i]) op(1, ROWS[i][26:18], ROWS[i][17:0], 0, 9'h000);
    foreach (ROWS[i]) rd_chk(ROWS[i][26:18], ROWS[i][17:0]);
    $display("table done");
    op(1, 9'h002, 18'h0beef, 1, 9'h010);
    repeat (4) @(negedge clk);
    check(rdata, 18'h2aaaa);
    rd_chk(9'h002, 18'h0beef);
    $display("same-cycle done");
    mode = MODE_ROM;
    op(1, 9'h001, 18'h00777, 0, 9'h000);
    rd_chk(9'h001, 18'h15555);
    mode = MODE_SDP;
    $display("rom done");
    pat = 18'h2a5c3;
    for (int i = 0; i < 18; i++) begin
      @(negedge clk);
      le = 1;
      la = 9'(72 + i);
      lb = pat[i];
    end
    @(negedge clk);
    le = 0;
    rd_chk(9'h004, pat);
    $display("preload done");
    @(negedge clk);
    iclr = 1;
    #1 check(rdata, pat);
    @(negedge clk);
    check(rdata, pat);
    iclr = 0;
    @(negedge clk);
    oclr = 1;
    #1 check(rdata, 18'h00000);
    @(negedge clk);
    oclr = 0;
    $display("clears done");
    // clock b idle: a write offered without its tick must not land
    csel = 1;
    tick = 0;
    op(1, 9'h002, 18'h11111, 0, 9'h000);
    tick = 1;
    rd_chk(9'h002, 18'h0beef);
    csel = 0;
    $display("clock b done");
    // bypass trades one cycle of latency for a combinational path
    byp = 1;
    rd_chk(9'h01f, 18'h00001);
    $display("bypass done");
    report_and_stop();
  end
endmodule : test_small_ram_block
